// ---- icseq_defs.svh ----
`ifndef ICSEQ_DEFS_SVH
`define ICSEQ_DEFS_SVH
`define ICSEQ_PC_W 13
`define ICSEQ_INSN_W 14
`define ICSEQ_DADDR_W 8
`define ICSEQ_DATA_W 8
`define ICSEQ_EE_ADDR_W 6
`define ICSEQ_EE_LAST 6'h3f
`define ICSEQ_RESET_VEC 13'h0000
`define ICSEQ_INT_VEC 13'h0004
`define ICSEQ_PM_MASK 13'h03ff
`endif

// ---- icseq_pkg.sv ----
package icseq_pkg;
  typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_THIRD, PH_FOURTH}
    icseq_phase_t;
endpackage : icseq_pkg

// ---- icseq_top.sv ----
`timescale 1ns/1ps
`include "icseq_defs.svh"
module icseq_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic master_reset_n,
  input wire logic rc_mode,
  input wire logic irq_req,
  input wire logic [12:0] pm_mask,
  output logic [12:0] pm_addr,
  input wire logic [13:0] pm_rdata,
  output logic [13:0] insn_q,
  output logic insn_valid,
  input wire logic flow_change,
  input wire logic [12:0] flow_target,
  output logic phase_first,
  output logic phase_second,
  output logic phase_third,
  output logic phase_fourth,
  output logic exec_active,
  input wire logic [7:0] dm_addr_in,
  input wire logic [7:0] dm_wdata_in,
  input wire logic dm_we_in,
  output logic [7:0] dm_addr,
  output logic dm_rd,
  output logic dm_wr,
  output logic [7:0] dm_wdata,
  input wire logic [5:0] ee_ptr_in,
  output logic [5:0] ee_ptr,
  output logic oscillator_output_pin
);
  logic rst;
  icseq_pkg::icseq_phase_t ph_q, ph_d;
  logic [12:0] pc_q, pc_d;
  logic [13:0] fetch_q;
  logic fvalid_q, xvalid_q, flush_q, clko_q;
  logic [7:0] daddr_q, dwdata_q;
  logic drd_q, dwr_q;
  logic [5:0] ee_q;

  assign rst = srst | ~master_reset_n;

  // All checks sample on the system clock and sleep during reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Phase sequencer
  always_comb begin
    unique case (ph_q)
      icseq_pkg::PH_FIRST: ph_d = icseq_pkg::PH_SECOND;
      icseq_pkg::PH_SECOND: ph_d = icseq_pkg::PH_THIRD;
      icseq_pkg::PH_THIRD: ph_d = icseq_pkg::PH_FOURTH;
      icseq_pkg::PH_FOURTH: ph_d = icseq_pkg::PH_FIRST;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) ph_q <= icseq_pkg::PH_FIRST;
    else ph_q <= ph_d;
  end

  assign phase_first = ~rst & (ph_q == icseq_pkg::PH_FIRST);
  assign phase_second = ~rst & (ph_q == icseq_pkg::PH_SECOND);
  assign phase_third = ~rst & (ph_q == icseq_pkg::PH_THIRD);
  assign phase_fourth = ~rst & (ph_q == icseq_pkg::PH_FOURTH);

  // Program counter: interrupt wins over flow change over increment
  wire [12:0] pc_inc = pc_q + 13'h0001;
  always_comb begin
    pc_d = pc_q;
    if (phase_first) begin
      if (irq_req) pc_d = `ICSEQ_INT_VEC;
      else if (flush_q) pc_d = pc_q;
      else pc_d = pc_inc;
    end
    if (phase_fourth && xvalid_q && flow_change) pc_d = flow_target;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) pc_q <= `ICSEQ_RESET_VEC;
    else pc_q <= pc_d;
  end
  assign pm_addr = pc_q & pm_mask;

  // Fetch stage; a flow change flushes the word fetched alongside
  // Validity of the instruction that enters execute at this edge
  wire xv_next = phase_first ? (fvalid_q & ~irq_req) : xvalid_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fetch_q <= 14'h0000;
      fvalid_q <= 1'b0;
      xvalid_q <= 1'b0;
      // Hold the pc once so the first fetch is the reset vector
      flush_q <= 1'b1;
      insn_q <= 14'h0000;
    end else begin
      if (phase_fourth) begin
        fetch_q <= pm_rdata;
        fvalid_q <= ~(xvalid_q & flow_change);
        flush_q <= xvalid_q & flow_change;
      end
      if (phase_first) begin
        insn_q <= fetch_q;
        xvalid_q <= xv_next;
        flush_q <= 1'b0;
      end
    end
  end
  assign insn_valid = xvalid_q;
  assign exec_active = xvalid_q & ~phase_first;

  // Data bus, independent of program bus
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      daddr_q <= 8'h00;
      dwdata_q <= 8'h00;
      drd_q <= 1'b0;
      dwr_q <= 1'b0;
      ee_q <= 6'h00;
    end else begin
      // Read flag follows the instruction now entering execute
      drd_q <= xv_next & (ph_d == icseq_pkg::PH_SECOND);
      dwr_q <= xvalid_q & dm_we_in & (ph_d == icseq_pkg::PH_FOURTH);
      daddr_q <= dm_addr_in;
      dwdata_q <= dm_wdata_in;
      ee_q <= ee_ptr_in & `ICSEQ_EE_LAST;
    end
  end
  assign dm_addr = daddr_q;
  assign dm_rd = drd_q;
  assign dm_wr = dwr_q;
  assign dm_wdata = dwdata_q;
  assign ee_ptr = ee_q;

  // Quarter-rate clock: high in phases one and two
  always_ff @(posedge clk_sys) begin
    if (rst) clko_q <= 1'b0;
    else clko_q <= rc_mode & ((ph_d == icseq_pkg::PH_FIRST) |
                  (ph_d == icseq_pkg::PH_SECOND));
  end
  assign oscillator_output_pin = clko_q;

  // Phase sequencer checks
  AST_PHASE_ORDER: assert property (
    phase_first |=> phase_second ##1 phase_third ##1 phase_fourth)
    else $error("phase order broken");
  AST_ONEHOT: assert property (
    $onehot({phase_first, phase_second, phase_third, phase_fourth}))
    else $error("phases overlap");

  // Program counter checks
  AST_PC_INC: assert property (
    phase_first && !irq_req && !flush_q |=> pc_q == $past(pc_q) + 13'h0001)
    else $error("pc did not advance");
  AST_INT_VEC: assert property (
    phase_first && irq_req |=> pc_q == `ICSEQ_INT_VEC)
    else $error("interrupt vector wrong");
  AST_IRQ_DROP: assert property (
    phase_first && irq_req |=> !insn_valid)
    else $error("word kept on interrupt entry");
  AST_WRAP: assert property (
    (pm_addr & ~pm_mask) == 13'h0000)
    else $error("address not wrapped");
  AST_PM_WRAP: assert property (
    phase_first && !irq_req && !flush_q |=>
      pm_addr == (($past(pm_addr) + 13'h0001) & pm_mask))
    else $error("address did not wrap on increment");

  // Fetch and execute checks
  AST_CAPTURE: assert property (
    phase_fourth |=> fetch_q == $past(pm_rdata))
    else $error("fetch not captured");
  AST_INSN_LOAD: assert property (
    phase_first |=> insn_q == $past(fetch_q))
    else $error("instruction not loaded");
  AST_FLUSH: assert property (
    phase_fourth && xvalid_q && flow_change |=> ##1 !xvalid_q)
    else $error("sequential word not discarded");
  AST_BRANCH_PC: assert property (
    phase_fourth && xvalid_q && flow_change |=> pc_q == $past(flow_target))
    else $error("branch target not loaded");
  AST_FLUSH_HOLD: assert property (
    phase_first && flush_q && !irq_req |=> pc_q == $past(pc_q))
    else $error("pc moved during refetch");

  // Data bus checks
  AST_RD_PHASE: assert property (
    dm_rd |-> phase_second)
    else $error("read outside phase two");
  AST_WR_PHASE: assert property (
    dm_wr |-> phase_fourth)
    else $error("write outside phase four");
  AST_RD_EACH: assert property (
    phase_second |-> dm_rd == insn_valid)
    else $error("operand read missing");
  AST_WR_EACH: assert property (
    phase_fourth |-> dm_wr == (insn_valid && $past(dm_we_in)))
    else $error("destination write wrong");
  AST_DATA_BUS: assert property (
    !$past(rst) |->
      dm_addr == $past(dm_addr_in) && dm_wdata == $past(dm_wdata_in))
    else $error("data bus not passed");
  AST_EE_PTR: assert property (
    !$past(rst) |-> ee_ptr == ($past(ee_ptr_in) & `ICSEQ_EE_LAST))
    else $error("pointer not passed");

  // Quarter-rate clock checks
  AST_INSTRUCTION_RATE_CLOCK_OUT: assert property (
    phase_first && rc_mode |=> oscillator_output_pin)
    else $error("quarter clock wrong");
  AST_CLK_RATE: assert property (
    !$past(rst) |-> oscillator_output_pin ==
      ($past(rc_mode) && (phase_first || phase_second)))
    else $error("quarter clock out of phase");

  // State at the first edge after reset
  AST_RESET: assert property (
    $fell(rst) |-> pc_q == `ICSEQ_RESET_VEC && !xvalid_q && !fvalid_q &&
      flush_q && phase_first)
    else $error("reset state wrong");

  COV_EXEC: cover property (
    insn_valid && dm_wr);
  COV_BRANCH: cover property (
    phase_fourth && xvalid_q && flow_change);
  COV_IRQ: cover property (
    phase_first && irq_req);
  COV_REFETCH: cover property (
    phase_first && flush_q && !irq_req);
  COV_RC_CLOCK: cover property (
    $rose(oscillator_output_pin));
endmodule : icseq_top

// ---- icseq_top_tb_top.sv ----
`timescale 1ns/1ps
module icseq_top_tb_top;
  logic clk_sys = 1'b0, srst = 1'b1, master_reset_n = 1'b1, rc_mode = 1'b0;
  logic irq_req = 1'b0, flow_change = 1'b0, dm_we_in = 1'b0;
  logic [12:0] pm_mask = 13'h03ff, flow_target = 13'h0000, pm_addr, exp_pc;
  logic [13:0] pm_rdata = 14'h0000, insn_q, prev_w;
  logic [7:0] dm_addr_in = 8'h00, dm_wdata_in = 8'h00, dm_addr, dm_wdata;
  logic [5:0] ee_ptr_in = 6'h00, ee_ptr;
  logic insn_valid, phase_first, phase_second, phase_third, phase_fourth;
  logic exec_active, dm_rd, dm_wr, oscillator_output_pin, flush;
  int err_count = 0, samples_checked = 0, cyc = 0;
  icseq_top u_icseq_top (.*);
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk
  task phs(input int q);
    chk({phase_first, phase_second, phase_third, phase_fourth},
      4'h8 >> q);
    if (q > 0) chk(oscillator_output_pin, rc_mode && q < 2);
  endtask : phs
  task icyc(input logic br, input logic [12:0] tgt, input logic irq,
    input logic we);
    logic [13:0] w;
    logic v;
    if (irq) exp_pc = 13'h0004;
    w = {1'b1, exp_pc} ^ 14'h0a5c;
    v = !flush && !irq;
    phs(0);
    pm_rdata = w;
    irq_req = irq;
    flow_change = br;
    flow_target = tgt;
    dm_we_in = we;
    dm_addr_in = w[7:0];
    dm_wdata_in = ~w[7:0];
    ee_ptr_in = w[5:0];
    @(negedge clk_sys);
    irq_req = 1'b0;
    phs(1);
    chk(pm_addr, exp_pc & pm_mask);
    if (v) chk({insn_valid, dm_rd, insn_q}, {2'h3, prev_w});
    else chk({insn_valid, dm_rd}, 2'h0);
    @(negedge clk_sys);
    phs(2);
    chk(exec_active, v);
    chk({dm_addr, dm_wdata}, {w[7:0], ~w[7:0]});
    chk(ee_ptr, w[5:0]);
    @(negedge clk_sys);
    phs(3);
    chk({dm_wr, dm_rd}, {v && we, 1'b0});
    @(negedge clk_sys);
    flush = br && v;
    exp_pc = flush ? tgt : exp_pc + 13'h0001;
    prev_w = w;
  endtask : icyc
  task rst(input logic use_pin);
    @(negedge clk_sys);
    if (use_pin) master_reset_n = 1'b0;
    else srst = 1'b1;
    repeat (4) begin
      @(negedge clk_sys);
      chk({phase_first, phase_second, phase_third, phase_fourth}, 4'h0);
    end
    srst = 1'b0;
    master_reset_n = 1'b1;
    // Phase one starts with the release; let the strobe settle
    #1;
    chk({phase_first, pm_addr}, {1'b1, 13'h0000});
    // First cycle runs with an empty execute stage
    {exp_pc, flush} = {13'h0000, 1'b1};
    $display("reset via pin %0d done", use_pin);
  endtask : rst
  task t_run;
    for (int i = 0; i < 12; i++) begin
      rc_mode = (i >= 6);
      icyc(1'b0, 13'h0000, 1'b0, i[0]);
    end
    $display("test run done");
  endtask : t_run
  task t_branch(input logic [12:0] t1, input logic [12:0] mask);
    pm_mask = mask;
    icyc(1'b1, t1, 1'b0, 1'b1);
    icyc(1'b1, 13'h1555, 1'b0, 1'b1);
    icyc(1'b1, t1 + 13'h0010, 1'b0, 1'b0);
    repeat (5) icyc(1'b0, 13'h0000, 1'b0, 1'b1);
    $display("test branch done");
  endtask : t_branch
  task t_irq;
    icyc(1'b0, 13'h0000, 1'b1, 1'b0);
    repeat (4) icyc(1'b0, 13'h0000, 1'b0, 1'b1);
    $display("test irq done");
  endtask : t_irq
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    rst(1'b0);
    t_run();
    t_branch(13'h0123, 13'h03ff);
    t_branch(13'h101d, 13'h001f);
    t_irq();
    rst(1'b1);
    t_run();
    end_of_test();
  end
endmodule : icseq_top_tb_top
